//--- pkg/capcomp_defines.svh
// Constants of the capture/compare/PWM unit: offsets, fields, reset values
//
// Function
// - Mode 0000 turns unit off, clears state
// - Modes 0001 and 0011 are reserved
// - Capture modes select falling, rising, 4th, 16th
// - Mode 0010 toggles output on match, sets flag
// - Modes 1000/1001 set/clear output, set flag
// - Mode 1010 match only sets flag
// - Mode 1011 flag, timer clear, converter start
// - Converter start exists on second unit only
// - Modes 11xx are PWM, ten-bit duty
// - Bits 7-6 read zero; duty bits else unused
// - Capture/compare use shared timer; PWM other
// - Capture loads sixteen-bit timer into held bytes
// - Every capture sets flag; only software clears
// - New capture overwrites old value, no overrun
// - Edges seen on actual pin level
// - Captures reflect a timer cleared elsewhere
// - Both PWMs share period, rising edges aligned
// - Prescaler clears when off or not capturing
// - Clearing control forces compare latch low
`ifndef CAPCOMP_DEFINES_SVH
`define CAPCOMP_DEFINES_SVH

// ==========================================================
// Register byte offsets on the bus
`define CC_OFS_CONTROL     5'h00
`define CC_OFS_HELD_LOW    5'h04
`define CC_OFS_HELD_HIGH   5'h08
`define CC_OFS_STATUS      5'h0c
`define CC_OFS_PORT        5'h10

// ==========================================================
// Field positions
`define CC_MODE_LSB        0
`define CC_MODE_MSB        3
`define CC_DUTY_LSB        4
`define CC_DUTY_MSB        5
`define CC_CONTROL_MASK    8'h3f
`define CC_STAT_FLAG_BIT   0
`define CC_PORT_DATA_BIT   0
`define CC_PORT_DIR_BIT    1
`define CC_PORT_LEVEL_BIT  2

// ==========================================================
// Reset values
`define CC_RST_CONTROL     8'h00
`define CC_RST_HELD        8'h00
`define CC_RST_DIRECTION   1'b1

// ==========================================================
// Prescaler terminal counts
`define CC_PRESCALE_4      4'h3
`define CC_PRESCALE_16     4'hf

`endif

//--- pkg/capcomp_pkg.sv
// Types and mode decode functions of the capture/compare/PWM unit
`include "capcomp_defines.svh"
package capcomp_pkg;

  // Unit mode field codes
  typedef enum logic [3:0] {
    MODE_OFF       = 4'h0,
    MODE_RSVD_A    = 4'h1,
    MODE_CMP_TOG   = 4'h2,
    MODE_RSVD_B    = 4'h3,
    MODE_CAP_FALL  = 4'h4,
    MODE_CAP_RISE  = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16= 4'h7,
    MODE_CMP_SET   = 4'h8,
    MODE_CMP_CLR   = 4'h9,
    MODE_CMP_SOFT  = 4'ha,
    MODE_CMP_SPEC  = 4'hb
  } mode_t;

  // Whole state of the register/compare part
  typedef struct packed {
    logic [7:0]  control;        // Control byte, bits 7-6 held zero
    logic [7:0]  held_low;       // Held value low byte
    logic [7:0]  held_high;      // Held value high byte
    logic        event_flag;     // Sticky unit event flag
    logic        port_data;      // Port data latch
    logic        pin_direction;  // 1 = pin is input
    logic        compare_latch;  // Compare output latch
    logic        match_prev;     // Match seen last cycle
    logic        pwm_out;        // PWM output level
    logic [9:0]  duty_active;    // Duty in use this period
    logic        ack;            // Bus answer phase
    logic [31:0] readdata;       // Bus read data
    logic        timer_clear;    // Shared timer clear pulse
    logic        converter_start;// Converter start pulse
  } unit_state_t;

  // Whole state of the capture detector
  typedef struct packed {
    logic       sync1;       // First synchroniser stage
    logic       sync2;       // Second synchroniser stage
    logic       level_prev;  // Previous synchronised level
    logic [3:0] prescale;    // Rising edge prescaler count
    logic       capture;     // Capture event pulse
  } detect_state_t;

  // Mode is one of the capture modes
  function automatic logic is_capture(input logic [3:0] m);
    return m[3:2] == 2'b01;
  endfunction : is_capture

  // Mode is one of the compare modes
  function automatic logic is_compare(input logic [3:0] m);
    return (m == MODE_CMP_TOG) || (m[3:2] == 2'b10);
  endfunction : is_compare

  // Mode is PWM
  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction : is_pwm

endpackage : capcomp_pkg

//--- pkg/capcomp_evt_if.sv
// Link between the unit core and its capture edge detector
`timescale 1ns/1ps
`default_nettype none
interface capcomp_evt_if;
  logic [3:0] mode;           // Current unit mode field
  logic       capture_pulse;  // Selected capture event
  logic       pin_level;      // Synchronised pin level

  modport core (output mode, input capture_pulse, input pin_level);
  modport detector (input mode, output capture_pulse, output pin_level);
endinterface : capcomp_evt_if
`default_nettype wire

//--- hdl/capcomp_capture_detect.sv
// Pin synchroniser, edge detector and capture prescaler
`timescale 1ns/1ps
`default_nettype none
`include "capcomp_defines.svh"
module capcomp_capture_detect (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pin_raw,
  capcomp_evt_if.detector  evt
);
  import capcomp_pkg::*;

  detect_state_t st;       // Registered state
  detect_state_t next_st;  // Next state

  // ==========================================================
  // Next state
  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    next_st = st;
    // Two stages before any logic reads the pin
    next_st.sync1 = pin_raw;
    next_st.sync2 = st.sync1;
    next_st.level_prev = st.sync2;
    // Edges of the real pin level, whoever drives it
    rise = st.sync2 & ~st.level_prev;
    fall = ~st.sync2 & st.level_prev;
    next_st.capture = 1'b0;
    if (!is_capture(evt.mode)) begin
      // Off or non-capture mode empties the prescaler
      next_st.prescale = 4'h0;
    end else begin
      unique case (evt.mode)
        MODE_CAP_FALL: next_st.capture = fall;
        MODE_CAP_RISE: next_st.capture = rise;
        MODE_CAP_RISE4: begin
          // Every fourth rising edge
          if (rise) begin
            next_st.capture  = (st.prescale[1:0] == 2'(`CC_PRESCALE_4));
            next_st.prescale = st.prescale + 4'h1;
          end
        end
        default: begin
          // Every sixteenth rising edge
          if (rise) begin
            next_st.capture  = (st.prescale == `CC_PRESCALE_16);
            next_st.prescale = st.prescale + 4'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt.capture_pulse = st.capture;
  assign evt.pin_level     = st.sync2;

endmodule : capcomp_capture_detect
`default_nettype wire

//--- hdl/capture_compare_unit.sv
// Capture/compare/PWM unit with its register slave
`timescale 1ns/1ps
`default_nettype none
`include "capcomp_defines.svh"
module capture_compare_unit #(
  parameter bit SECOND_UNIT = 1'b0                  // Set on the second unit instance
) (
  input  wire logic        clk,                     // System clock
  input  wire logic        rst_n,                   // Asynchronous reset, active low
  // Register bus
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Time bases
  input  wire logic [15:0] shared_time_base_count,  // Shared sixteen-bit timer
  input  wire logic [7:0]  pwm_time_base_count,     // PWM timer count
  input  wire logic [1:0]  pwm_time_base_fine,      // PWM timer low bits
  input  wire logic        pwm_period_restart,      // PWM period start pulse
  output logic             shared_timer_clear,      // Clear shared timer pulse
  // Converter
  input  wire logic        converter_enabled,       // Converter is enabled
  output logic             converter_start,         // Converter start pulse
  // Event and pin
  output logic             unit_event_flag,         // Sticky event flag
  input  wire logic        unit_signal_pin_in,      // Pin level
  output logic             unit_signal_pin_out,     // Pin drive value
  output logic             unit_signal_pin_oe_n     // Pin enable, low drives
);
  import capcomp_pkg::*;

  localparam unit_state_t RESET_STATE = '{
    control:       `CC_RST_CONTROL,
    held_low:      `CC_RST_HELD,
    held_high:     `CC_RST_HELD,
    pin_direction: `CC_RST_DIRECTION,
    default:       '0
  };

  unit_state_t st;         // Registered state
  unit_state_t next_st;    // Next state
  capcomp_evt_if evt ();   // Link to the detector

  logic [3:0]  mode;       // Current mode field
  logic        bus_req;    // A bus request is present
  logic        wr_take;    // Write takes effect this edge
  logic        cmp_match;  // Timer equals held value
  logic        cmp_edge;   // First cycle of a match
  logic [9:0]  duty_next;  // Duty value from registers
  logic        clr_hit;    // Software clears the flag

  // ==========================================================
  // Capture detector
  capcomp_capture_detect u_detect (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_raw (unit_signal_pin_in),
    .evt     (evt)
  );

  assign mode     = st.control[`CC_MODE_MSB:`CC_MODE_LSB];
  assign evt.mode = mode;

  // ==========================================================
  // Bus handshake terms
  assign bus_req   = avs_read | avs_write;
  assign wr_take   = avs_write & st.ack & avs_byteenable[0];
  assign avs_waitrequest = bus_req & ~st.ack;

  // Compare against the shared timer only
  assign cmp_match = {st.held_high, st.held_low} == shared_time_base_count;
  assign cmp_edge  = cmp_match & ~st.match_prev;

  // Ten-bit duty: low compare byte above control bits 5-4
  assign duty_next = {st.held_low, st.control[`CC_DUTY_MSB:`CC_DUTY_LSB]};

  assign clr_hit = wr_take && (avs_address == `CC_OFS_STATUS) && avs_writedata[`CC_STAT_FLAG_BIT];

  // ==========================================================
  // Read decode, unmapped reads as zero
  function automatic logic [31:0] read_mux(input unit_state_t s, input logic [4:0] a, input logic lvl);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `CC_OFS_CONTROL:   r[7:0] = s.control & `CC_CONTROL_MASK;
      `CC_OFS_HELD_LOW:  r[7:0] = s.held_low;
      `CC_OFS_HELD_HIGH: r[7:0] = s.held_high;
      `CC_OFS_STATUS:    r[`CC_STAT_FLAG_BIT] = s.event_flag;
      `CC_OFS_PORT: begin
        r[`CC_PORT_DATA_BIT]  = s.port_data;
        r[`CC_PORT_DIR_BIT]   = s.pin_direction;
        r[`CC_PORT_LEVEL_BIT] = lvl;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // ==========================================================
  // Next state
  always_comb begin
    logic set_flag;
    set_flag = 1'b0;
    next_st = st;
    next_st.timer_clear     = 1'b0;
    next_st.converter_start = 1'b0;
    next_st.match_prev      = cmp_match;

    // Bus: answer one cycle after the request appears
    if (bus_req && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.readdata = read_mux(st, avs_address, evt.pin_level);
    end else begin
      next_st.ack = 1'b0;
    end

    // Register writes
    if (wr_take) begin
      unique case (avs_address)
        `CC_OFS_CONTROL: begin
          // Bits 7-6 are not implemented
          next_st.control = avs_writedata[7:0] & `CC_CONTROL_MASK;
          if (avs_writedata[3:0] == MODE_OFF) begin
            next_st.compare_latch = 1'b0;
          end
        end
        `CC_OFS_HELD_LOW:  next_st.held_low  = avs_writedata[7:0];
        `CC_OFS_HELD_HIGH: next_st.held_high = avs_writedata[7:0];
        `CC_OFS_PORT: begin
          next_st.port_data     = avs_writedata[`CC_PORT_DATA_BIT];
          next_st.pin_direction = avs_writedata[`CC_PORT_DIR_BIT];
        end
        default: ;  // Status handled below, unmapped ignored
      endcase
    end

    // Mode-dependent behaviour
    if (mode == MODE_OFF) begin
      // Unit off: compare and PWM state held cleared
      next_st.compare_latch = 1'b0;
      next_st.pwm_out       = 1'b0;
      next_st.duty_active   = 10'h000;
    end else if (is_capture(mode)) begin
      // Latest capture always replaces the held value
      if (evt.capture_pulse) begin
        next_st.held_high = shared_time_base_count[15:8];
        next_st.held_low  = shared_time_base_count[7:0];
        set_flag = 1'b1;
      end
    end else if (is_compare(mode)) begin
      if (cmp_edge) begin
        set_flag = 1'b1;
        unique case (mode)
          MODE_CMP_TOG: next_st.compare_latch = ~st.compare_latch;
          MODE_CMP_SET: next_st.compare_latch = 1'b1;
          MODE_CMP_CLR: next_st.compare_latch = 1'b0;
          MODE_CMP_SOFT: ;
          default: begin
            // Special event: clear timer, start converter
            next_st.timer_clear     = 1'b1;
            next_st.converter_start = SECOND_UNIT & converter_enabled;
          end
        endcase
      end
    end else if (is_pwm(mode)) begin
      // Common period restart aligns both units' rising edges
      if (pwm_period_restart) begin
        next_st.duty_active = duty_next;
        next_st.pwm_out     = (duty_next != 10'h000);
      end else if ({pwm_time_base_count, pwm_time_base_fine} == st.duty_active) begin
        next_st.pwm_out = 1'b0;
      end
    end
    // Reserved codes 0001 and 0011 do nothing further

    // Flag: hardware set wins over software clear
    if (set_flag) begin
      next_st.event_flag = 1'b1;
    end else if (clr_hit) begin
      next_st.event_flag = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata       = st.readdata;
  assign shared_timer_clear = st.timer_clear;
  assign converter_start    = st.converter_start;
  assign unit_event_flag    = st.event_flag;
  assign unit_signal_pin_oe_n = st.pin_direction;

  // Pin value: compare latch, PWM level or port latch
  always_comb begin
    if (is_compare(mode)) begin
      unit_signal_pin_out = st.compare_latch;
    end else if (is_pwm(mode)) begin
      unit_signal_pin_out = st.pwm_out;
    end else begin
      unit_signal_pin_out = st.port_data;
    end
  end

endmodule : capture_compare_unit
`default_nettype wire

//--- test/capcomp_asserts.sv
// Port checker of the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "capcomp_defines.svh"
module capcomp_asserts #(
  parameter bit SECOND_UNIT = 1'b0
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        converter_enabled,
  input wire logic        converter_start,
  input wire logic        shared_timer_clear,
  input wire logic        unit_event_flag,
  input wire logic        unit_signal_pin_out
);
  // ==========
  // Mode shadow
  logic       wr_ok;  // Write taken, low byte on
  logic [3:0] mode;   // Shadow of mode field
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Follow control writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode <= 4'h0;
    else if (wr_ok && avs_address == `CC_OFS_CONTROL) mode <= avs_writedata[3:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  a_flag_sticky: assert property (
    unit_event_flag && !(wr_ok && avs_address == `CC_OFS_STATUS && avs_writedata[0]) |=> unit_event_flag)
    else $error("event flag dropped without clear");
  a_conv_second_only: assert property (
    !SECOND_UNIT |-> !converter_start) else $error("converter start on first unit");
  a_conv_needs_enable: assert property (
    converter_start |-> $past(converter_enabled) && shared_timer_clear) else $error("bad converter start");
  a_clear_one_pulse: assert property (
    shared_timer_clear |=> !shared_timer_clear) else $error("timer clear longer than a cycle");
  a_set_on_match: assert property (
    mode == 4'h8 && $rose(unit_event_flag) |-> unit_signal_pin_out) else $error("set mode pin low");
  a_clr_on_match: assert property (
    mode == 4'h9 && $rose(unit_event_flag) |-> !unit_signal_pin_out) else $error("clear mode pin high");
  a_toggle_match: assert property (
    mode == 4'h2 && $rose(unit_event_flag) |-> unit_signal_pin_out != $past(unit_signal_pin_out))
    else $error("toggle mode pin did not toggle");
  a_soft_pin_hold: assert property (
    mode == 4'ha && $past(mode) == 4'ha |-> $stable(unit_signal_pin_out)) else $error("soft mode moved pin");
  a_ctrl_top_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == `CC_OFS_CONTROL |-> avs_readdata[7:6] == 2'b00)
    else $error("control bits 7-6 not zero");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
endmodule : capcomp_asserts
bind capture_compare_unit capcomp_asserts #(.SECOND_UNIT(SECOND_UNIT)) u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .converter_enabled(converter_enabled),
  .converter_start(converter_start), .shared_timer_clear(shared_timer_clear),
  .unit_event_flag(unit_event_flag), .unit_signal_pin_out(unit_signal_pin_out)
);
`default_nettype wire

//--- test/capcomp_pin_source.sv
// Far-side source of capture edges on the unit pin
`timescale 1ns/1ps
`default_nettype none
module capcomp_pin_source (
  input  wire logic clk,
  output var logic  level
);
  initial level = 1'b0;
  // Move the pin, then rest long enough to be seen
  task automatic drive(input logic lv);
    @(posedge clk);
    level <= lv;
    repeat (8) @(posedge clk);
  endtask : drive
  // Whole pulses, rise then fall
  task automatic pulses(input int n);
    repeat (n) begin
      drive(1'b1);
      drive(1'b0);
    end
  endtask : pulses
endmodule : capcomp_pin_source
`default_nettype wire

//--- test/test_capture_compare_unit.sv
// Self-checking bench of the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "capcomp_defines.svh"
module test_capture_compare_unit;
  import capcomp_pkg::*;
  // ==========
  // Signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] tmr = 16'h0000;  // Shared timer
  logic [15:0] ldv = 16'h0000;  // Timer load value
  logic        ld = 1'b0;       // Timer load request
  logic        run_tmr = 1'b1;  // Timer runs
  logic [9:0]  pwm = 10'h000;   // PWM timer
  logic        conv_en = 1'b0;  // Converter enabled
  logic        conv_seen = 1'b0;
  logic        tclr, conv, flag, pin_out, oe_n, src_lvl, pin;
  int          miscompares = 0;
  int          tests_run = 0;
  always #12.5 clk = ~clk;
  // Time bases and converter watch
  always @(posedge clk) begin
    if (tclr) tmr <= 16'h0000;
    else if (ld) tmr <= ldv;
    else if (run_tmr) tmr <= tmr + 16'h0001;
    pwm <= pwm + 10'h001;
    if (conv) conv_seen <= 1'b1;
  end
  assign pin = oe_n ? src_lvl : pin_out;
  capcomp_pin_source src (.clk(clk), .level(src_lvl));
  capture_compare_unit #(.SECOND_UNIT(1'b1)) uut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .shared_time_base_count(tmr), .pwm_time_base_count(pwm[9:2]),
    .pwm_time_base_fine(pwm[1:0]), .pwm_period_restart(pwm == 10'h000), .shared_timer_clear(tclr),
    .converter_enabled(conv_en), .converter_start(conv), .unit_event_flag(flag),
    .unit_signal_pin_in(pin), .unit_signal_pin_out(pin_out), .unit_signal_pin_oe_n(oe_n)
  );
  // ==========
  // Helpers
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic timeout();
    miscompares++;
    print_verdict();
  endtask : timeout
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One bus access, held until answered
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= {{24{wr}}, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 10) timeout();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, 4'h1, r);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, 4'hf, r);
    check(r, exp);
  endtask : rdc
  task automatic load(input logic [15:0] v, input logic run);
    @(posedge clk);
    ldv <= v;
    ld <= 1'b1;
    run_tmr <= run;
    @(posedge clk);
    ld <= 1'b0;
  endtask : load
  task automatic wait_flag();
    int i;
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      if (flag === 1'b1) break;
    end
    if (i == 40) timeout();
  endtask : wait_flag
  task automatic wait_pwm(input logic [9:0] v);
    int i;
    for (i = 0; i < 1100; i++) begin
      @(negedge clk);
      if (pwm == v) break;
    end
    if (i == 1100) timeout();
  endtask : wait_pwm
  // Optional off step, new mode, flag cleared
  task automatic set_mode(input logic [7:0] m, input logic z);
    if (z) wr(`CC_OFS_CONTROL, 8'h00);
    wr(`CC_OFS_CONTROL, m);
    wr(`CC_OFS_STATUS, 8'h01);
  endtask : set_mode
  task automatic cmp(input logic [7:0] m, input logic z, input logic exp);
    set_mode(m, z);
    load(16'h0030, 1'b1);
    wait_flag();
    check(pin_out, exp);
  endtask : cmp
  // ==========
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    rdc(`CC_OFS_CONTROL, 32'h0);
    // Write without the low byte lane is ignored
    bus(1'b1, `CC_OFS_HELD_LOW, 8'h55, 4'he, r);
    rdc(`CC_OFS_HELD_LOW, 32'h0);
    rdc(`CC_OFS_PORT, 32'h2);
    wr(`CC_OFS_CONTROL, 8'hff);
    rdc(`CC_OFS_CONTROL, 32'h3f);
    wr(5'h14, 8'h55);
    rdc(5'h14, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic t_capture();
    load(16'ha5c3, 1'b0);
    set_mode({4'h0, MODE_CAP_FALL}, 1'b1);
    src.drive(1'b1);
    check(flag, 1'b0);
    src.drive(1'b0);
    wait_flag();
    rdc(`CC_OFS_HELD_LOW, 32'hc3);
    rdc(`CC_OFS_HELD_HIGH, 32'ha5);
    load(16'h1234, 1'b0);
    src.pulses(1);
    check(flag, 1'b1);
    rdc(`CC_OFS_HELD_LOW, 32'h34);
    set_mode({4'h0, MODE_CAP_RISE}, 1'b1);
    src.drive(1'b1);
    check(flag, 1'b1);
    src.drive(1'b0);
    set_mode({4'h0, MODE_CAP_RISE4}, 1'b1);
    src.pulses(2);
    set_mode({4'h0, MODE_CAP_RISE4}, 1'b1);
    src.pulses(3);
    check(flag, 1'b0);
    src.pulses(1);
    check(flag, 1'b1);
    set_mode({4'h0, MODE_CAP_RISE16}, 1'b1);
    src.pulses(15);
    check(flag, 1'b0);
    src.pulses(1);
    check(flag, 1'b1);
    $display("capture test done");
  endtask : t_capture
  task automatic t_compare();
    wr(`CC_OFS_PORT, 8'h00);
    wr(`CC_OFS_HELD_LOW, 8'h40);
    wr(`CC_OFS_HELD_HIGH, 8'h00);
    // Reserved code: a match must not raise the flag
    set_mode(8'h01, 1'b1);
    load(16'h0038, 1'b1);
    repeat (16) @(posedge clk);
    check(flag, 1'b0);
    check(pin_out, 1'b0);
    cmp(8'h02, 1'b1, 1'b1);
    set_mode(8'h08, 1'b1);
    check(pin_out, 1'b0);
    cmp(8'h08, 1'b0, 1'b1);
    cmp(8'h09, 1'b0, 1'b0);
    cmp(8'h0a, 1'b1, 1'b0);
    @(posedge clk);
    conv_en <= 1'b1;
    cmp(8'h0b, 1'b1, 1'b0);
    repeat (2) @(posedge clk);
    check({31'h0, tmr < 16'h0010}, 32'h1);
    check(conv_seen, 1'b1);
    set_mode(8'h05, 1'b1);
    wr(`CC_OFS_PORT, 8'h01);
    wait_flag();
    check(flag, 1'b1);
    check(oe_n, 1'b0);
    $display("compare test done");
  endtask : t_compare
  task automatic t_pwm();
    wr(`CC_OFS_HELD_LOW, 8'h40);
    set_mode(8'h2c, 1'b1);
    wait_pwm(10'h3ff);
    wait_pwm(10'h005);
    check(pin_out, 1'b1);
    wait_pwm(10'h101);
    check(pin_out, 1'b1);
    wait_pwm(10'h104);
    check(pin_out, 1'b0);
    $display("pwm test done");
  endtask : t_pwm
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_capture();
    t_compare();
    t_pwm();
    print_verdict();
  end
endmodule : test_capture_compare_unit
`default_nettype wire
